// File: core/dpbt_regs.vh
// register offsets, field positions, reset values and limits of the dma pci control block
`ifndef DPBT_REGS_VH
`define DPBT_REGS_VH

// ==========================================================================
// register map
`define DPBT_ADDR_W            12
`define DPBT_OFS_ISO_CTRL      12'h800
`define DPBT_OFS_ASY_CTRL      12'h808
`define DPBT_RST_ISO_CTRL      32'h0000_7373
`define DPBT_RST_ASY_CTRL      32'h0010_7373

// ==========================================================================
// field positions (both registers share the low sixteen bits)
`define DPBT_TX_BURST_HI       15
`define DPBT_TX_BURST_LO       12
`define DPBT_TX_THR_HI         11
`define DPBT_TX_THR_LO         8
`define DPBT_RX_BURST_HI       7
`define DPBT_RX_BURST_LO       4
`define DPBT_RX_THR_HI         3
`define DPBT_RX_THR_LO         0
`define DPBT_AT_FIFO_HI        23
`define DPBT_AT_FIFO_LO        16
`define DPBT_RETRY_MAX_BIT     24

// ==========================================================================
// writable masks, limits
`define DPBT_ISO_WMASK         32'h0000_ffff
`define DPBT_ASY_WMASK         32'h01ff_ffff
`define DPBT_AT_FIFO_MAX       8'h20
`define DPBT_QUAD_SHIFT        4

`endif

// File: core/dpbt_engine_gate.v
// request and burst-limit logic for one dma engine direction
`timescale 1ns/1ps
`default_nettype none

module dpbt_engine_gate #(
	parameter CW = 10
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rst_i,
	// programmed fields
	input  wire [3:0]    burst_n_i,
	input  wire [3:0]    thr_n_i,
	input  wire          is_tx_i,
	// fifo and buffer state in quadlets
	input  wire [CW-1:0] fifo_level_i,
	input  wire [CW-1:0] remain_i,
	input  wire          pkt_done_i,
	input  wire          active_i,
	input  wire          gnt_i,
	// results
	output wire          req_o,
	output reg  [8:0]    burst_max_o
);

	// ======================================================================
	// limit decode: 16*(n+1) quadlets
	// five bits hold n+1 up to 16, so the scaled limit fits CW+5 bits
	wire [4:0] thr_q   = {1'b0, thr_n_i} + 5'h01;
	wire [CW+4:0] thr_quads = {{(CW-4){1'b0}}, thr_q, 4'h0};
	wire [CW+4:0] lvl  = {5'h00, fifo_level_i};
	wire [CW+4:0] rem  = {5'h00, remain_i};
	wire          thr_met = lvl >= thr_quads;
	// tx: fetch early when less is left to fetch than space; rx: flush early
	wire          early = is_tx_i ? (rem < lvl) : ((lvl > rem) | pkt_done_i);
	wire          want = active_i & (thr_met | early);

	// held until granted while the condition stands, dropped otherwise
	assign req_o = want & ~gnt_i;

	// burst limit registered so the pci side sees a stable value
	always @(posedge clk_i) begin
		if (rst_i) begin
			burst_max_o <= 9'h000;
		end else begin
			burst_max_o <= {1'b0, burst_n_i, 4'h0} + 9'h010;
		end
	end

endmodule // dpbt_engine_gate

`default_nettype wire

// File: core/dpbt_dma_pci_ctrl.v
// dma pci burst and threshold control: registers plus per-engine gating
// How it works
// - iso transmit fetch per pci transaction capped at 16*(n+1) quadlets
// - iso transmit requests bus once free fifo space reaches threshold
// - iso transmit may request early if remaining fetch below free space
// - iso receive write per transaction capped at 16*(n+1) quadlets
// - iso receive requests bus once fifo data reaches threshold
// - iso receive requests early on buffer-end overflow or whole packet
// - retry bit forces max at fifo threshold on retried packets; resets 0
// - link told packet ready at 16*n quadlets; n resets 0x10, max 0x20
// - link also told ready whenever the complete packet is in fifo
// - async transmit and read response fetch capped at 16*(n+1)
// - async transmit units request bus once free space reaches threshold
// - async transmit units may request early if remaining fetch is smaller
// - async receive and physical write capped at 16*(n+1) per transaction
// - async receive requests bus once fifo data reaches threshold
// - async receive requests early on buffer overflow or complete packet
// - four-bit fields take n up to 0xf, 16 to 256 quadlets
// - real bursts may be shorter due to packet, buffer, fifo, cache line
// - iso register resets 0x00007373, async register 0x00107373
// - registers at 0x800 and 0x808, loadable from a serial eeprom
`timescale 1ns/1ps
`default_nettype none
`include "dpbt_regs.vh"

module dpbt_dma_pci_ctrl #(
	parameter CW = 10
) (
	// clock and reset
	input  wire          CLOCK_I,
	input  wire          RESET_I,
	// register port
	input  wire [11:0]   REG_ADDR_I,
	input  wire          REG_WR_I,
	input  wire          REG_RD_I,
	input  wire [31:0]   REG_WDATA_I,
	output reg  [31:0]   REG_RDATA_O,
	// eeprom load
	input  wire          EE_LOAD_I,
	input  wire [11:0]   EE_ADDR_I,
	input  wire [31:0]   EE_DATA_I,
	// iso transmit engine
	input  wire [CW-1:0] IT_FREE_I,
	input  wire [CW-1:0] IT_REMAIN_I,
	input  wire          IT_ACTIVE_I,
	input  wire          IT_GNT_I,
	output wire          IT_REQ_O,
	output wire [8:0]    IT_BURST_MAX_O,
	// iso receive engine
	input  wire [CW-1:0] IR_LEVEL_I,
	input  wire [CW-1:0] IR_BUF_SPACE_I,
	input  wire          IR_PKT_DONE_I,
	input  wire          IR_ACTIVE_I,
	input  wire          IR_GNT_I,
	output wire          IR_REQ_O,
	output wire [8:0]    IR_BURST_MAX_O,
	// async transmit and physical read response engine
	input  wire [CW-1:0] AT_FREE_I,
	input  wire [CW-1:0] AT_REMAIN_I,
	input  wire          AT_ACTIVE_I,
	input  wire          AT_GNT_I,
	output wire          AT_REQ_O,
	output wire [8:0]    AT_BURST_MAX_O,
	// async receive and physical write engine
	input  wire [CW-1:0] AR_LEVEL_I,
	input  wire [CW-1:0] AR_BUF_SPACE_I,
	input  wire          AR_PKT_DONE_I,
	input  wire          AR_ACTIVE_I,
	input  wire          AR_GNT_I,
	output wire          AR_REQ_O,
	output wire [8:0]    AR_BURST_MAX_O,
	// async transmit fifo to link
	input  wire [CW-1:0] ATF_LEVEL_I,
	input  wire          ATF_PKT_WHOLE_I,
	input  wire          ATF_RETRY_I,
	output reg           LINK_PKT_READY_O
);

	// ======================================================================
	// control registers
	reg  [31:0] iso_dma_pci_control_r;
	reg  [31:0] async_dma_pci_control_r;

	// eeprom load wins over a software write in the same cycle, since the
	// eeprom only runs at start-up while the link is still off
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			iso_dma_pci_control_r   <= `DPBT_RST_ISO_CTRL;
			async_dma_pci_control_r <= `DPBT_RST_ASY_CTRL;
		end else if (EE_LOAD_I) begin
			if (EE_ADDR_I == `DPBT_OFS_ISO_CTRL)
				iso_dma_pci_control_r <= EE_DATA_I & `DPBT_ISO_WMASK;
			if (EE_ADDR_I == `DPBT_OFS_ASY_CTRL)
				async_dma_pci_control_r <= EE_DATA_I & `DPBT_ASY_WMASK;
		end else if (REG_WR_I) begin
			// no interlock on link enable: software keeps writes off then
			if (REG_ADDR_I == `DPBT_OFS_ISO_CTRL)
				iso_dma_pci_control_r <= REG_WDATA_I & `DPBT_ISO_WMASK;
			if (REG_ADDR_I == `DPBT_OFS_ASY_CTRL)
				async_dma_pci_control_r <= REG_WDATA_I & `DPBT_ASY_WMASK;
		end
	end

	// read data registered; unmapped offsets read zero
	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			REG_RDATA_O <= 32'h0000_0000;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				`DPBT_OFS_ISO_CTRL: REG_RDATA_O <= iso_dma_pci_control_r;
				`DPBT_OFS_ASY_CTRL: REG_RDATA_O <= async_dma_pci_control_r;
				default:            REG_RDATA_O <= 32'h0000_0000;
			endcase
		end
	end

	// ======================================================================
	// per-engine request gates; all four nibbles span 0..0xf
	// burst maxima are upper limits, the pci side may cut shorter
	dpbt_engine_gate #(.CW(CW)) u_it (
		.clk_i        (CLOCK_I),
		.rst_i        (RESET_I),
		.burst_n_i    (iso_dma_pci_control_r[`DPBT_TX_BURST_HI:`DPBT_TX_BURST_LO]),
		.thr_n_i      (iso_dma_pci_control_r[`DPBT_TX_THR_HI:`DPBT_TX_THR_LO]),
		.is_tx_i      (1'b1),
		.fifo_level_i (IT_FREE_I),
		.remain_i     (IT_REMAIN_I),
		.pkt_done_i   (1'b0),
		.active_i     (IT_ACTIVE_I),
		.gnt_i        (IT_GNT_I),
		.req_o        (IT_REQ_O),
		.burst_max_o  (IT_BURST_MAX_O)
	);

	dpbt_engine_gate #(.CW(CW)) u_ir (
		.clk_i        (CLOCK_I),
		.rst_i        (RESET_I),
		.burst_n_i    (iso_dma_pci_control_r[`DPBT_RX_BURST_HI:`DPBT_RX_BURST_LO]),
		.thr_n_i      (iso_dma_pci_control_r[`DPBT_RX_THR_HI:`DPBT_RX_THR_LO]),
		.is_tx_i      (1'b0),
		.fifo_level_i (IR_LEVEL_I),
		.remain_i     (IR_BUF_SPACE_I),
		.pkt_done_i   (IR_PKT_DONE_I),
		.active_i     (IR_ACTIVE_I),
		.gnt_i        (IR_GNT_I),
		.req_o        (IR_REQ_O),
		.burst_max_o  (IR_BURST_MAX_O)
	);

	dpbt_engine_gate #(.CW(CW)) u_at (
		.clk_i        (CLOCK_I),
		.rst_i        (RESET_I),
		.burst_n_i    (async_dma_pci_control_r[`DPBT_TX_BURST_HI:`DPBT_TX_BURST_LO]),
		.thr_n_i      (async_dma_pci_control_r[`DPBT_TX_THR_HI:`DPBT_TX_THR_LO]),
		.is_tx_i      (1'b1),
		.fifo_level_i (AT_FREE_I),
		.remain_i     (AT_REMAIN_I),
		.pkt_done_i   (1'b0),
		.active_i     (AT_ACTIVE_I),
		.gnt_i        (AT_GNT_I),
		.req_o        (AT_REQ_O),
		.burst_max_o  (AT_BURST_MAX_O)
	);

	dpbt_engine_gate #(.CW(CW)) u_ar (
		.clk_i        (CLOCK_I),
		.rst_i        (RESET_I),
		.burst_n_i    (async_dma_pci_control_r[`DPBT_RX_BURST_HI:`DPBT_RX_BURST_LO]),
		.thr_n_i      (async_dma_pci_control_r[`DPBT_RX_THR_HI:`DPBT_RX_THR_LO]),
		.is_tx_i      (1'b0),
		.fifo_level_i (AR_LEVEL_I),
		.remain_i     (AR_BUF_SPACE_I),
		.pkt_done_i   (AR_PKT_DONE_I),
		.active_i     (AR_ACTIVE_I),
		.gnt_i        (AR_GNT_I),
		.req_o        (AR_REQ_O),
		.burst_max_o  (AR_BURST_MAX_O)
	);

	// ======================================================================
	// link notification from the async transmit fifo
	wire [7:0] at_n_raw = async_dma_pci_control_r[`DPBT_AT_FIFO_HI:`DPBT_AT_FIFO_LO];
	wire       retry_max = async_dma_pci_control_r[`DPBT_RETRY_MAX_BIT];
	// values above the legal top are clamped so they cannot stall the link
	wire [7:0] at_n_clip = (at_n_raw > `DPBT_AT_FIFO_MAX) ? `DPBT_AT_FIFO_MAX
	                                                      : at_n_raw;
	wire [7:0] at_n_use  = (ATF_RETRY_I & retry_max) ? `DPBT_AT_FIFO_MAX
	                                                 : at_n_clip;
	wire [CW+4:0] at_thr = {{(CW-3){1'b0}}, at_n_use} << `DPBT_QUAD_SHIFT;
	wire [CW+4:0] at_lvl = {5'h00, ATF_LEVEL_I};

	always @(posedge CLOCK_I) begin
		if (RESET_I) begin
			LINK_PKT_READY_O <= 1'b0;
		end else begin
			LINK_PKT_READY_O <= (at_lvl >= at_thr)
			                  | ATF_PKT_WHOLE_I;
		end
	end

endmodule // dpbt_dma_pci_ctrl

`default_nettype wire

// File: sim/dpbt_ctrl_sva.sv
// port checker for the dma pci burst and threshold control block
`timescale 1ns/1ps
`default_nettype none
module dpbt_ctrl_sva #(parameter CW = 10) (
	input wire logic CLOCK_I, RESET_I, REG_RD_I, IT_ACTIVE_I, IT_GNT_I,
	input wire logic IT_REQ_O, IR_PKT_DONE_I, IR_ACTIVE_I, IR_GNT_I, IR_REQ_O,
	input wire logic AT_ACTIVE_I, AT_GNT_I, AT_REQ_O, AR_ACTIVE_I, AR_GNT_I,
	input wire logic AR_REQ_O, ATF_PKT_WHOLE_I, LINK_PKT_READY_O,
	input wire logic [11:0] REG_ADDR_I,
	input wire logic [31:0] REG_RDATA_O,
	input wire logic [CW-1:0] IT_FREE_I, IT_REMAIN_I, AT_FREE_I, AT_REMAIN_I,
	input wire logic [CW-1:0] AR_LEVEL_I, AR_BUF_SPACE_I,
	input wire logic [8:0] IT_BURST_MAX_O
);
	// ==========
	// relations at the ports; reset is synchronous, one clock domain
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	it_early_a: assert property (IT_ACTIVE_I && !IT_GNT_I &&
		IT_REMAIN_I < IT_FREE_I |-> IT_REQ_O) else $error("iso tx no early req");
	at_early_a: assert property (AT_ACTIVE_I && !AT_GNT_I &&
		AT_REMAIN_I < AT_FREE_I |-> AT_REQ_O) else $error("async tx no early req");
	ir_whole_a: assert property (IR_ACTIVE_I && !IR_GNT_I &&
		IR_PKT_DONE_I |-> IR_REQ_O) else $error("iso rx no req on packet");
	ar_space_a: assert property (AR_ACTIVE_I && !AR_GNT_I &&
		AR_LEVEL_I > AR_BUF_SPACE_I |-> AR_REQ_O) else $error("async rx no req");
	req_idle_a: assert property (!IR_ACTIVE_I || IR_GNT_I |->
		!IR_REQ_O) else $error("iso rx req while idle or granted");
	link_whole_a: assert property (ATF_PKT_WHOLE_I |=>
		LINK_PKT_READY_O) else $error("link not told of whole packet");
	it_burst_a: assert property (!$past(RESET_I) |->
		IT_BURST_MAX_O[3:0] == 4'h0 && IT_BURST_MAX_O != 9'h000)
		else $error("iso tx burst cap not a nonzero multiple of 16");
	rd_unmap_a: assert property (REG_RD_I && REG_ADDR_I != 12'h800 &&
		REG_ADDR_I != 12'h808 |=> REG_RDATA_O == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // dpbt_ctrl_sva
bind dpbt_dma_pci_ctrl dpbt_ctrl_sva #(.CW(CW)) u_sva (.*);
`default_nettype wire

// File: sim/dpbt_pci_arb_model.sv
// pci host arbiter model that grants dma requests after a set wait
`timescale 1ns/1ps
`default_nettype none
module dpbt_pci_arb_model #(parameter int WAIT = 4) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] req_i,
	output var  logic [3:0] gnt_o
);
	// ==========
	// arbiter
	logic [2:0] cnt [4];
	// one-cycle grant after WAIT cycles of steady request; a request
	// withdrawn early loses its place, as on a busy host bus
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i || gnt_o[i]) begin
				cnt[i] <= 3'h0;
				gnt_o[i] <= 1'b0;
			end else if (req_i[i]) begin
				cnt[i] <= cnt[i] + 3'h1;
				gnt_o[i] <= (cnt[i] == 3'(WAIT - 1));
			end else
				cnt[i] <= 3'h0;
		end
	end
endmodule // dpbt_pci_arb_model
`default_nettype wire

// File: sim/test_dma_pci_burst_threshold_ctrl.sv
// self-checking bench for the dma pci burst and threshold control
`timescale 1ns/1ps
`default_nettype none
module test_dma_pci_burst_threshold_ctrl;
	// ==========
	// stimulus, partner and dut
	logic CLOCK_I = 0, RESET_I = 1, REG_WR_I = 0, REG_RD_I = 0, EE_LOAD_I = 0;
	logic [11:0] REG_ADDR_I = 0, EE_ADDR_I = 0;
	logic [31:0] REG_WDATA_I = 0, EE_DATA_I = 0, REG_RDATA_O;
	logic [9:0] IT_FREE_I = 0, IT_REMAIN_I = 1023, IR_LEVEL_I = 0;
	logic [9:0] IR_BUF_SPACE_I = 1023, AT_FREE_I = 0, AT_REMAIN_I = 1023;
	logic [9:0] AR_LEVEL_I = 0, AR_BUF_SPACE_I = 1023, ATF_LEVEL_I = 0;
	logic IT_ACTIVE_I = 0, IR_ACTIVE_I = 0, AT_ACTIVE_I = 0, AR_ACTIVE_I = 0;
	logic IR_PKT_DONE_I = 0, AR_PKT_DONE_I = 0, ATF_PKT_WHOLE_I = 0;
	logic ATF_RETRY_I = 0, IT_REQ_O, IR_REQ_O, AT_REQ_O, AR_REQ_O;
	logic LINK_PKT_READY_O, IT_GNT_I, IR_GNT_I, AT_GNT_I, AR_GNT_I;
	logic [8:0] IT_BURST_MAX_O, IR_BURST_MAX_O, AT_BURST_MAX_O, AR_BURST_MAX_O;
	wire logic [3:0] reqs = {IT_REQ_O, IR_REQ_O, AT_REQ_O, AR_REQ_O};
	int errors = 0, checks = 0;
	// link table: async register, fifo level, {retry, whole, ready}
	logic [31:0] lk_reg [8] = '{32'h0002_0000, 32'h0002_0000, 32'h0002_0000,
		32'h0002_0000, 32'h0102_0000, 32'h0102_0000, 32'h0102_0000,
		32'h0021_0000};
	logic [9:0] lk_lvl [8] = '{31, 32, 0, 32, 32, 512, 32, 512};
	logic [2:0] lk_rwe [8] = '{0, 1, 3, 5, 4, 5, 1, 1};
	dpbt_dma_pci_ctrl #(.CW(10)) dut (.*);
	dpbt_pci_arb_model #(.WAIT(4)) u_arb (.clk_i(CLOCK_I), .rst_i(RESET_I),
		.req_i(reqs), .gnt_o({IT_GNT_I, IR_GNT_I, AT_GNT_I, AR_GNT_I}));
	always #2.5 CLOCK_I = ~CLOCK_I;
	// ==========
	// access tasks
	task automatic chk(input string nm, input logic [31:0] ex, got);
		checks++;
		if (got !== ex) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// the eeprom strobe shares the write cycle; it wins over a bus write
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit ee);
		@(posedge CLOCK_I);
		{REG_WR_I, EE_LOAD_I} <= {1'b1, ee};
		{REG_ADDR_I, EE_ADDR_I} <= {a, a};
		// a losing bus write carries other data, so priority shows
		REG_WDATA_I <= ee ? ~d : d;
		EE_DATA_I <= d;
		@(posedge CLOCK_I);
		{REG_WR_I, EE_LOAD_I} <= 2'b00;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		@(posedge CLOCK_I);
		REG_RD_I <= 1;
		REG_ADDR_I <= a;
		@(posedge CLOCK_I);
		REG_RD_I <= 0;
		#1 chk("read data", ex, REG_RDATA_O);
	endtask
	// same fill level on all four engines; requests are combinational
	task automatic lvl(input logic [9:0] v);
		@(posedge CLOCK_I);
		{IT_FREE_I, AT_FREE_I, IR_LEVEL_I, AR_LEVEL_I} <= {4{v}};
		#1;
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========
	// tests; the run needs about two hundred cycles
	initial begin
		repeat (20000) @(posedge CLOCK_I);
		errors++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge CLOCK_I);
		RESET_I <= 0;
		rd(12'h800, 32'h0000_7373);
		rd(12'h808, 32'h0010_7373);
		chk("caps", {IT_BURST_MAX_O, AR_BURST_MAX_O}, {2{9'h080}});
		rd(12'h840, 32'h0000_0000);
		wr(12'h800, 32'hffff_ffff, 0);
		rd(12'h800, 32'h0000_ffff);
		wr(12'h808, 32'hffff_ffff, 0);
		rd(12'h808, 32'h01ff_ffff);
		wr(12'h800, 32'h1234_5678, 1);
		rd(12'h800, 32'h0000_5678);
		{IT_ACTIVE_I, IR_ACTIVE_I, AT_ACTIVE_I, AR_ACTIVE_I} <= 4'hf;
		// every field value, one quadlet short of and at the threshold
		for (int n = 0; n < 16; n++) begin
			wr(12'h800, {16'h0000, {4{n[3:0]}}}, 0);
			wr(12'h808, {16'h0010, {4{n[3:0]}}}, 0);
			lvl(10'(16 * n + 15));
			chk("reqs below", 4'h0, reqs);
			lvl(10'(16 * n + 16));
			chk("reqs at", 4'hf, reqs);
			chk("iso caps", {IT_BURST_MAX_O, IR_BURST_MAX_O}, {2{9'(16 * n + 16)}});
			chk("asy caps", {AT_BURST_MAX_O, AR_BURST_MAX_O}, {2{9'(16 * n + 16)}});
			lvl(0);
		end
		// early paths only, thresholds at their top
		{IT_REMAIN_I, AT_REMAIN_I} <= {2{10'd50}};
		{IR_BUF_SPACE_I, AR_BUF_SPACE_I} <= {2{10'd10}};
		lvl(100);
		chk("early reqs", 4'hf, reqs);
		{IT_REMAIN_I, AT_REMAIN_I, IR_BUF_SPACE_I, AR_BUF_SPACE_I} <= {4{10'd1023}};
		{IR_PKT_DONE_I, AR_PKT_DONE_I} <= 2'b11;
		lvl(100);
		chk("packet reqs", 4'b0101, reqs);
		for (int i = 0; i < 20 && IR_GNT_I !== 1'b1; i++)
			#5;
		chk("grant", {IR_GNT_I, IR_REQ_O}, 2'b10);
		{IT_ACTIVE_I, IR_ACTIVE_I, AT_ACTIVE_I, AR_ACTIVE_I} <= 4'h0;
		lvl(100);
		chk("idle reqs", 4'h0, reqs);
		for (int k = 0; k < 8; k++) begin
			{ATF_RETRY_I, ATF_PKT_WHOLE_I} <= lk_rwe[k][2:1];
			ATF_LEVEL_I <= lk_lvl[k];
			wr(12'h808, lk_reg[k], 0);
			repeat (2) @(posedge CLOCK_I);
			#1 chk("link ready", lk_rwe[k][0], LINK_PKT_READY_O);
		end
		finish_test();
	end
endmodule // test_dma_pci_burst_threshold_ctrl
`default_nettype wire
